// *** hw/pmw_consts.svh ***
// Constants for the power mode and wake-up controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files; holds definitions only.
// Function
// - Select code 111 moves system onto slow clock.
// - Slow switch completes only with slow oscillator stable.
// - Codes 000 to 110 pick divided fast clock.
// - Fast oscillator restart reported through stable flag.
// - Halt with both holds clear enters sleep.
// - Halt with only slow hold enters low-clock idle.
// - Halt with both holds set enters dual-clock idle.
// - Halt with only fast hold enters high-clock idle.
// - Power-down keeps memory, registers and ports intact.
// - Halt sets power-down flag, clears timeout flag.
// - Halt clears watchdog; counting follows watchdog enable.
// - Power-up and watchdog clear clear power-down flag.
// - Watchdog overflow wakes, sets timeout, resets PC/SP.
// - Wake on pin fall, interrupt or watchdog overflow.
// - Per-pin wake enable; falling edge wakes device.
// - Pin wake resumes after the halt instruction.
// - Masked or stack-full interrupt wake resumes after halt.
// - Enabled interrupt with free stack gets normal response.
// - Interrupt already pending at halt cannot wake.
// - Three-bit select maps fast divisors and slow clock.
// - Fast stable flag reads zero, then one when stable.
// - New clock applies after the switching delay.
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define PMW_OFF_SYS_CLK_CTRL 8'h00
`define PMW_OFF_HS_OSC_CTRL 8'h04
`define PMW_OFF_STATUS 8'h08
`define PMW_OFF_PA_WAKE 8'h0c
`define PMW_OFF_PB_WAKE 8'h10

// Field positions.
`define PMW_SEL_MSB 7
`define PMW_SEL_LSB 5
`define PMW_HS_HOLD_BIT 1
`define PMW_LS_HOLD_BIT 0
`define PMW_HS_STABLE_BIT 1
`define PMW_HS_EN_BIT 0

// Reset values and the slow clock select code.
`define PMW_SEL_RST 3'h0
`define PMW_HS_EN_RST 1'b1
`define PMW_SEL_SLOW 3'h7

// Timing: periods in ns as printed, cycle counts derived from the 100 ns clock.
`define PMW_CLK_PERIOD_NS 100
`define PMW_HS_PERIOD_NS 250
`define PMW_LS_PERIOD_NS 31250
`define PMW_HS_CYC ((`PMW_HS_PERIOD_NS + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)
`define PMW_LS_CYC ((`PMW_LS_PERIOD_NS + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)
`define PMW_SW_SYS_PERIODS 4

`endif

// *** hw/pmw_pkg.sv ***
// Types shared by the power mode and wake-up controller.
// Assumes nothing beyond a SystemVerilog compiler.
package pmw_pkg;
    typedef enum logic [1:0] {
        PMW_ST_RUN,
        PMW_ST_SWITCH,
        PMW_ST_HALTED,
        PMW_ST_WAKE
    } pmw_state_e;

    typedef enum logic [1:0] {
        PMW_CAUSE_NONE,
        PMW_CAUSE_PIN,
        PMW_CAUSE_IRQ,
        PMW_CAUSE_WDT
    } pmw_cause_e;
endpackage

// *** hw/pmw_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; multi-bit values are not coherent.
`timescale 1ns/1ps
module pmw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** hw/pmw_ctrl.sv ***
// Operating mode, clock select and wake-up controller with an AXI4-Lite register port.
// Assumes the core pulses halt and watchdog-clear for one cycle, and that oscillator
// ready levels and port pins arrive asynchronously.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "pmw_consts.svh"
module pmw_ctrl #(
    parameter int N_IRQ = 4,
    parameter int PIN_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_instr,
    input wire logic watchdog_clear_instr,
    input wire logic wdt_enable,
    input wire logic wdt_overflow,
    input wire logic [N_IRQ-1:0] irq_req,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic stack_full,
    input wire logic [PIN_W-1:0] port_a_pins,
    input wire logic [PIN_W-1:0] port_b_pins,
    input wire logic hs_osc_ready,
    input wire logic ls_osc_ready,
    output logic hs_osc_on,
    output logic ls_osc_on,
    output logic sub_clk_en,
    output logic sys_clk_en,
    output logic [2:0] sys_clk_sel,
    output logic cpu_run,
    output logic power_down_flag,
    output logic watchdog_timeout_flag,
    output logic wdt_counter_clear,
    output logic wdt_run,
    output logic pc_sp_reset,
    output logic resume_after_halt,
    output logic irq_response
);
    import pmw_pkg::*;

    localparam logic [15:0] HS_CYC = 16'(`PMW_HS_CYC);
    localparam logic [15:0] LS_CYC = 16'(`PMW_LS_CYC);

    pmw_state_e st_q;
    pmw_cause_e cause_q;
    logic [2:0] sel_reg_q;
    logic hs_hold_q, ls_hold_q, hs_en_q, hs_flag_q;
    logic [PIN_W-1:0] pa_wake_q, pb_wake_q, pa_prev_q, pb_prev_q;
    logic [N_IRQ-1:0] irq_armed_q;
    logic [15:0] sw_cnt_q;
    logic [2:0] sw_tgt_q;
    logic [1:0] ready_s;
    logic [2*PIN_W-1:0] pins_s;
    logic hs_rdy_s, ls_rdy_s;
    logic [PIN_W-1:0] pa_s, pb_s;
    logic take_halt, pin_wake, wdt_wake, cur_src_ok;
    logic [N_IRQ-1:0] irq_wake;
    logic wr_go, rd_hit;
    logic [7:0] aw_addr_q, ar_addr;
    logic [31:0] w_data_q, rd_val;
    logic aw_have_q, w_have_q, w_lane0_q;

    // Oscillator ready levels and port pins come from other clocks.
    pmw_sync #(.W(2)) u_sync_rdy (
        .clk(clk),
        .rst_n(rst_n),
        .d({hs_osc_ready, ls_osc_ready}),
        .q(ready_s)
    );
    pmw_sync #(.W(2*PIN_W)) u_sync_pins (
        .clk(clk),
        .rst_n(rst_n),
        .d({port_a_pins, port_b_pins}),
        .q(pins_s)
    );
    assign hs_rdy_s = ready_s[1];
    assign ls_rdy_s = ready_s[0];
    assign pa_s = pins_s[2*PIN_W-1:PIN_W];
    assign pb_s = pins_s[PIN_W-1:0];

    // Clock period of one select code in controller cycles.
    function automatic logic [15:0] sel_cyc(input logic [2:0] code);
        if (code == `PMW_SEL_SLOW) begin
            return LS_CYC;
        end
        return 16'(HS_CYC << code);
    endfunction

    // Worst-case switch delay: four current periods plus 1.5 current and 0.5 target.
    function automatic logic [15:0] sw_delay(input logic [2:0] cur, input logic [2:0] tgt);
        logic [17:0] c, t;
        c = {2'b00, sel_cyc(cur)};
        t = {2'b00, sel_cyc(tgt)};
        return 16'((18'(`PMW_SW_SYS_PERIODS * 2 + 3) * c + t + 18'h1) >> 1);
    endfunction

    // Wake detection: enabled falling pin edges, fresh interrupts, watchdog overflow.
    assign pin_wake = |((pa_prev_q & ~pa_s & pa_wake_q) | (pb_prev_q & ~pb_s & pb_wake_q));
    assign irq_wake = irq_req & irq_armed_q;
    assign wdt_wake = wdt_overflow;
    assign take_halt = halt_instr && (st_q == PMW_ST_RUN || st_q == PMW_ST_SWITCH);
    assign cur_src_ok = (sys_clk_sel == `PMW_SEL_SLOW) ? ls_rdy_s : hs_rdy_s;

    // Previous pin levels for edge detection, read from the second sync stage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pa_prev_q <= '0;
            pb_prev_q <= '0;
        end else begin
            pa_prev_q <= pa_s;
            pb_prev_q <= pb_s;
        end
    end

    // Mode sequencer. A select change waits for the target source, then the delay.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= PMW_ST_RUN;
            sys_clk_sel <= `PMW_SEL_RST;
            sw_tgt_q <= `PMW_SEL_RST;
            sw_cnt_q <= 16'h0000;
            cause_q <= PMW_CAUSE_NONE;
            irq_armed_q <= '0;
        end else begin
            case (st_q)
                PMW_ST_RUN: begin
                    if (take_halt) begin
                        st_q <= PMW_ST_HALTED;
                        irq_armed_q <= ~irq_req;
                    end else if (sel_reg_q != sys_clk_sel) begin
                        st_q <= PMW_ST_SWITCH;
                        sw_tgt_q <= sel_reg_q;
                        sw_cnt_q <= sw_delay(sys_clk_sel, sel_reg_q);
                    end
                end
                PMW_ST_SWITCH: begin
                    if (take_halt) begin
                        // The pending change is retried from the run state after wake-up.
                        st_q <= PMW_ST_HALTED;
                        irq_armed_q <= ~irq_req;
                    end else if (sw_tgt_q == `PMW_SEL_SLOW && !ls_rdy_s) begin
                        sw_cnt_q <= sw_cnt_q;
                    end else if (sw_tgt_q != `PMW_SEL_SLOW && !hs_rdy_s) begin
                        sw_cnt_q <= sw_cnt_q;
                    end else if (sw_cnt_q > 16'h0001) begin
                        sw_cnt_q <= sw_cnt_q - 16'h0001;
                    end else begin
                        sys_clk_sel <= sw_tgt_q;
                        st_q <= PMW_ST_RUN;
                    end
                end
                PMW_ST_HALTED: begin
                    // Watchdog has top priority, then interrupts, then pins.
                    if (wdt_wake) begin
                        cause_q <= PMW_CAUSE_WDT;
                        st_q <= PMW_ST_WAKE;
                    end else if (|irq_wake) begin
                        cause_q <= PMW_CAUSE_IRQ;
                        st_q <= PMW_ST_WAKE;
                    end else if (pin_wake) begin
                        cause_q <= PMW_CAUSE_PIN;
                        st_q <= PMW_ST_WAKE;
                    end
                end
                PMW_ST_WAKE: begin
                    if (cur_src_ok) begin
                        st_q <= PMW_ST_RUN;
                    end
                end
                default: begin
                    st_q <= PMW_ST_RUN;
                end
            endcase
        end
    end

    // Clock and oscillator outputs follow the state; the core clock gating keeps
    // memory, registers and ports frozen without any reset of them.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_osc_on <= 1'b1;
            ls_osc_on <= 1'b1;
            sub_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
            cpu_run <= 1'b1;
            wdt_run <= 1'b0;
        end else begin
            wdt_run <= wdt_enable;
            if (st_q == PMW_ST_HALTED) begin
                hs_osc_on <= hs_hold_q;
                ls_osc_on <= ls_hold_q | wdt_enable;
                sub_clk_en <= ls_hold_q;
                sys_clk_en <= (ls_hold_q && sys_clk_sel == `PMW_SEL_SLOW) ||
                    (hs_hold_q && sys_clk_sel != `PMW_SEL_SLOW);
                cpu_run <= 1'b0;
            end else begin
                hs_osc_on <= hs_en_q || sys_clk_sel != `PMW_SEL_SLOW ||
                    (st_q == PMW_ST_SWITCH && sw_tgt_q != `PMW_SEL_SLOW);
                ls_osc_on <= 1'b1;
                sub_clk_en <= 1'b1;
                sys_clk_en <= (st_q != PMW_ST_WAKE) || cur_src_ok;
                cpu_run <= (st_q != PMW_ST_WAKE);
            end
        end
    end

    // Fast oscillator stable flag drops when the oscillator is stopped and follows the ready level once it is on.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_flag_q <= 1'b0;
        end else if (!hs_osc_on) begin
            hs_flag_q <= 1'b0;
        end else begin
            hs_flag_q <= hs_rdy_s;
        end
    end

    // Status flags: the halt set wins over a watchdog clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_down_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else begin
            if (take_halt) begin
                power_down_flag <= 1'b1;
                watchdog_timeout_flag <= 1'b0;
            end else if (watchdog_clear_instr) begin
                power_down_flag <= 1'b0;
            end
            if (st_q == PMW_ST_HALTED && wdt_wake) begin
                watchdog_timeout_flag <= 1'b1;
            end
        end
    end

    // One-cycle pulses towards the core and watchdog.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdt_counter_clear <= 1'b0;
            pc_sp_reset <= 1'b0;
            resume_after_halt <= 1'b0;
            irq_response <= 1'b0;
        end else begin
            wdt_counter_clear <= take_halt || watchdog_clear_instr;
            pc_sp_reset <= 1'b0;
            resume_after_halt <= 1'b0;
            irq_response <= 1'b0;
            if (st_q == PMW_ST_WAKE && cur_src_ok) begin
                pc_sp_reset <= (cause_q == PMW_CAUSE_WDT);
                resume_after_halt <= (cause_q == PMW_CAUSE_PIN) ||
                    (cause_q == PMW_CAUSE_IRQ && (stack_full || !(|(irq_req & irq_enable))));
                irq_response <= (cause_q == PMW_CAUSE_IRQ) && !stack_full &&
                    (|(irq_req & irq_enable));
            end
        end
    end

    // AXI4-Lite write side: address and data are latched independently.
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_lane0_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_lane0_q <= s_axi_wstrb[0]; // Strobes are only valid alongside wvalid.
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[7:2] <= `PMW_OFF_PB_WAKE >> 2) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage. Only byte lane 0 carries fields.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_reg_q <= `PMW_SEL_RST;
            hs_hold_q <= 1'b0;
            ls_hold_q <= 1'b0;
            hs_en_q <= `PMW_HS_EN_RST;
            pa_wake_q <= '0;
            pb_wake_q <= '0;
        end else if (wr_go && w_lane0_q) begin
            case ({aw_addr_q[7:2], 2'b00})
                `PMW_OFF_SYS_CLK_CTRL: begin
                    sel_reg_q <= w_data_q[`PMW_SEL_MSB:`PMW_SEL_LSB];
                    hs_hold_q <= w_data_q[`PMW_HS_HOLD_BIT];
                    ls_hold_q <= w_data_q[`PMW_LS_HOLD_BIT];
                end
                `PMW_OFF_HS_OSC_CTRL: hs_en_q <= w_data_q[`PMW_HS_EN_BIT];
                `PMW_OFF_PA_WAKE: pa_wake_q <= w_data_q[PIN_W-1:0];
                `PMW_OFF_PB_WAKE: pb_wake_q <= w_data_q[PIN_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; the status word shows flags, wake cause, state and the active clock select.
    assign ar_addr = {s_axi_araddr[7:2], 2'b00};
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (ar_addr)
            `PMW_OFF_SYS_CLK_CTRL: rd_val = {24'h000000, sel_reg_q, 3'h0, hs_hold_q, ls_hold_q};
            `PMW_OFF_HS_OSC_CTRL: rd_val = {30'h0, hs_flag_q, hs_en_q};
            `PMW_OFF_STATUS: rd_val = {23'h000000, sys_clk_sel, st_q, cause_q,
                                       watchdog_timeout_flag, power_down_flag};
            `PMW_OFF_PA_WAKE: rd_val = 32'(pa_wake_q);
            `PMW_OFF_PB_WAKE: rd_val = 32'(pb_wake_q);
            default: rd_hit = 1'b0;
        endcase
    end

    // Read side answers one cycle after the address is taken.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks on the sequencer and flags.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic halted_2;
    logic halted_prev_q;

    // Remembers the last state so the mode checks skip the entry cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halted_prev_q <= 1'b0;
        end else begin
            halted_prev_q <= st_q == PMW_ST_HALTED;
        end
    end
    assign halted_2 = st_q == PMW_ST_HALTED && halted_prev_q;

    property p_halt_flags;
        take_halt |=> power_down_flag && !watchdog_timeout_flag && wdt_counter_clear;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
    property p_clr_pdf;
        watchdog_clear_instr && !take_halt |=> !power_down_flag ##0 wdt_counter_clear;
    endproperty
    a_clr_pdf: assert property (p_clr_pdf) else $error("pdf not cleared");
    property p_sleep;
        halted_2 && !hs_hold_q && !ls_hold_q |-> !sys_clk_en && !hs_osc_on && !cpu_run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
    property p_idle_low;
        halted_2 && !hs_hold_q && ls_hold_q |-> !hs_osc_on && sub_clk_en && !cpu_run;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("low idle wrong");
    property p_idle_dual;
        halted_2 && hs_hold_q && ls_hold_q |-> hs_osc_on && sub_clk_en && sys_clk_en;
    endproperty
    a_idle_dual: assert property (p_idle_dual) else $error("dual idle wrong");
    property p_idle_high;
        halted_2 && hs_hold_q && !ls_hold_q |-> hs_osc_on && !sub_clk_en && !cpu_run;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("high idle wrong");
    property p_wdt_wake;
        st_q == PMW_ST_HALTED && wdt_wake |=> watchdog_timeout_flag && st_q == PMW_ST_WAKE;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake wrong");
    property p_slow_stable;
        $changed(sys_clk_sel) && sys_clk_sel == `PMW_SEL_SLOW |-> $past(ls_rdy_s);
    endproperty
    a_slow_stable: assert property (p_slow_stable) else $error("slow switch unstable");
    property p_pin_resume;
        st_q == PMW_ST_WAKE && cur_src_ok && cause_q == PMW_CAUSE_PIN |=>
            resume_after_halt && !irq_response ##1 !resume_after_halt;
    endproperty
    a_pin_resume: assert property (p_pin_resume) else $error("pin resume wrong");

    c_sleep: cover property (take_halt && !hs_hold_q && !ls_hold_q);
    c_pin_wake: cover property (st_q == PMW_ST_HALTED && pin_wake);
    c_irq_resp: cover property (irq_response);
    c_slow: cover property ($changed(sys_clk_sel) && sys_clk_sel == `PMW_SEL_SLOW);
endmodule

// *** tb/pmw_core_model.sv ***
// Stand-in for the core and both oscillators seen by the controller.
// Assumes the controller's clock; the bench calls pulse() just after an edge.
`timescale 1ns/1ps
module pmw_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hs_osc_on,
    input wire logic ls_osc_on,
    output logic halt_instr,
    output logic watchdog_clear_instr,
    output logic hs_osc_ready,
    output logic ls_osc_ready
);
    logic [2:0] hs_q;
    logic [2:0] ls_q;
    // Oscillators need a few cycles to restart, so a wake from a mode that stopped the clock source must wait for them.
    always_ff @(posedge clk) begin
        hs_q <= (!rst_n || !hs_osc_on) ? 3'h0 : hs_q + {2'h0, hs_q != 3'h5};
        ls_q <= (!rst_n || !ls_osc_on) ? 3'h0 : ls_q + {2'h0, ls_q != 3'h5};
    end
    assign hs_osc_ready = hs_q == 3'h5;
    assign ls_osc_ready = ls_q == 3'h5;
    initial begin
        halt_instr = 1'b0;
        watchdog_clear_instr = 1'b0;
    end
    // One-cycle instruction pulse: halt when w is 0, watchdog clear when 1.
    task automatic pulse(input logic w);
        halt_instr <= !w;
        watchdog_clear_instr <= w;
        @(posedge clk);
        halt_instr <= 1'b0;
        watchdog_clear_instr <= 1'b0;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the power mode and wake-up controller.
// Assumes the core stand-in pmw_core_model and a 10 MHz clock.
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, port_a_pins, port_b_pins;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, irq_req, irq_enable;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic halt_instr, watchdog_clear_instr, wdt_enable, wdt_overflow, stack_full, hs_osc_ready;
    logic ls_osc_ready, hs_osc_on, ls_osc_on, sub_clk_en, sys_clk_en, cpu_run, power_down_flag;
    logic watchdog_timeout_flag, wdt_counter_clear, wdt_run, pc_sp_reset, resume_after_halt;
    logic irq_response;
    logic [2:0] sys_clk_sel;
    int n_fail, n_tests, k;
    pmw_ctrl dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .halt_instr, .watchdog_clear_instr, .wdt_enable, .wdt_overflow, .irq_req,
        .irq_enable, .stack_full, .port_a_pins, .port_b_pins, .hs_osc_ready, .ls_osc_ready,
        .hs_osc_on, .ls_osc_on, .sub_clk_en, .sys_clk_en, .sys_clk_sel, .cpu_run,
        .power_down_flag, .watchdog_timeout_flag, .wdt_counter_clear, .wdt_run, .pc_sp_reset,
        .resume_after_halt, .irq_response);
    pmw_core_model core (.clk, .rst_n, .hs_osc_on, .ls_osc_on, .halt_instr,
        .watchdog_clear_instr, .hs_osc_ready, .ls_osc_ready);
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bus tasks start just after an edge and end one edge after the answer.
    task automatic wr(logic [7:0] a, logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdr(logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait on a pulse or level; a miss shows up in the following check.
    task automatic till(ref logic s);
        for (k = 0; k < 5000 && s !== 1'b1; k++) @(posedge clk);
    endtask
    task automatic t_halt(logic hs, logic ls);
        wr(8'h0c, 32'h1);
        wr(8'h00, {30'h0, hs, ls});
        core.pulse(1'b0);
        repeat (3) @(posedge clk);
        chk("pdf", power_down_flag, 1);
        chk("timeout", watchdog_timeout_flag, 0);
        chk("run", cpu_run, 0);
        chk("hs_on", hs_osc_on, hs);
        chk("sub", sub_clk_en, ls);
        chk("sysclk", sys_clk_en, hs);
        chk("ls_on", ls_osc_on, ls);
        port_a_pins <= 8'hfe;
        till(resume_after_halt);
        chk("resume", resume_after_halt, 1);
        port_a_pins <= 8'hff;
        repeat (4) @(posedge clk);
        chk("run", cpu_run, 1);
        $display("halt test %0d%0d done", hs, ls);
    endtask
    task automatic t_wdt;
        wdt_enable <= 1'b1;
        wr(8'h00, 32'h0);
        core.pulse(1'b0);
        till(wdt_counter_clear);
        chk("wclr", wdt_counter_clear, 1);
        chk("wrun", wdt_run, 1);
        @(posedge clk);
        chk("lson", ls_osc_on, 1);
        wdt_overflow <= 1'b1;
        @(posedge clk);
        wdt_overflow <= 1'b0;
        till(pc_sp_reset);
        chk("pcsp", pc_sp_reset, 1);
        chk("to", watchdog_timeout_flag, 1);
        chk("pdf", power_down_flag, 1);
        repeat (4) @(posedge clk);
        core.pulse(1'b1);
        @(posedge clk);
        chk("pdf", power_down_flag, 0);
        $display("watchdog test done");
    endtask
    task automatic t_irq;
        irq_req <= 4'h1;
        core.pulse(1'b0);
        repeat (30) @(posedge clk);
        chk("run", cpu_run, 0);
        irq_req <= 4'h3;
        irq_enable <= 4'h2;
        till(irq_response);
        chk("irq", irq_response, 1);
        irq_req <= 4'h0;
        repeat (4) @(posedge clk);
        // Same enabled wake with the stack full: no response, resume after halt.
        core.pulse(1'b0);
        repeat (3) @(posedge clk);
        irq_req <= 4'h2;
        stack_full <= 1'b1;
        till(resume_after_halt);
        chk("stkfull", resume_after_halt, 1);
        chk("noirq", irq_response, 0);
        irq_req <= 4'h0;
        stack_full <= 1'b0;
        repeat (4) @(posedge clk);
        $display("interrupt test done");
    endtask
    task automatic t_sw;
        rdr(8'h04);
        chk("hsctl", rd[1:0], 2'h3);
        rdr(8'h14);
        chk("resp", rr, 2'h2);
        wr(8'h14, 32'h0);
        chk("bresp", rr, 2'h2);
        wr(8'h00, 32'he0);
        chk("sel", sys_clk_sel, 0);
        for (k = 0; k < 5000 && sys_clk_sel !== 3'h7; k++) @(posedge clk);
        chk("sel", sys_clk_sel, 7);
        wr(8'h04, 32'h0);
        rdr(8'h04);
        chk("hsflag", rd[1:0], 2'h0);
        wr(8'h00, 32'h40);
        for (k = 0; k < 5000 && sys_clk_sel !== 3'h2; k++) @(posedge clk);
        chk("sel", sys_clk_sel, 2);
        $display("switch test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // The run should take under 10000 cycles; this cuts a hang short.
    initial begin
        #6000000;
        n_fail++;
        conclude();
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {wdt_enable, wdt_overflow, stack_full, irq_req, irq_enable} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        port_a_pins = 8'hff;
        port_b_pins = 8'hff;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_sw();
        for (int i = 0; i < 4; i++) t_halt(i[1], i[0]);
        t_wdt();
        t_irq();
        conclude();
    end
endmodule
